//--- armdc_regs.svh
// constants for the readback scheduler and margin code control
`ifndef ARMDC_REGS_SVH
`define ARMDC_REGS_SVH
`define ARMDC_NUM_CH 12
`define ARMDC_NUM_DAC 6
`define ARMDC_AVG_PASSES 16
`define ARMDC_MIDCODE 8'h7f
`define ARMDC_CODE_FULL 12'hfff
`define ARMDC_CH_TIME_NS 500000
`define ARMDC_CLK_PERIOD_NS 100
`define ARMDC_CH_CYCLES (`ARMDC_CH_TIME_NS / `ARMDC_CLK_PERIOD_NS)
`define ARMDC_BUF_SETTLE_CYCLES 16
`endif

//--- armdc_pkg.sv
// types for the readback scheduler and margin code control
package armdc_pkg;
  typedef enum logic [1:0] {
    ARMDC_IDLE = 2'b00,
    ARMDC_CONV = 2'b01,
    ARMDC_NEXT = 2'b11,
    ARMDC_POST = 2'b10
  } armdc_scan_t;
  typedef enum logic [1:0] {
    ARMDC_BOFF = 2'b00,
    ARMDC_BTRACK = 2'b01,
    ARMDC_BDRIVE = 2'b11,
    ARMDC_BHIZ = 2'b10
  } armdc_buf_t;
  typedef logic [7:0] armdc_code_t;
  typedef logic [11:0] armdc_res_t;
endpackage : armdc_pkg

//--- armdc_margin_chan.sv
// one margin code channel: clipping, range and glitch-free buffer enable
`timescale 1ns/10ps
`include "armdc_regs.svh"
module armdc_margin_chan
  import armdc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // settings
  input wire logic enable,
  input wire logic [7:0] code,
  input wire logic [7:0] upper_clip,
  input wire logic [7:0] lower_clip,
  input wire logic [1:0] range_sel,
  // buffer controls
  output logic [7:0] applied_code_r,
  output logic [1:0] range_r,
  output logic buf_power_r,
  output logic buf_src_dac_r,
  output logic buf_out_en_n_r
);
  armdc_buf_t state_r;
  logic [4:0] settle_r;
  logic inverted;

  assign inverted = lower_clip > upper_clip;

  // clipped code and range applied every cycle
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      applied_code_r <= `ARMDC_MIDCODE;
      range_r <= 2'h0;
    end
    else
    begin
      range_r <= range_sel;
      if (code < lower_clip)
        applied_code_r <= lower_clip;
      else if (code > upper_clip)
        applied_code_r <= upper_clip;
      else
        applied_code_r <= code;
    end
  end

  // power up tracking the pin, then switch to the code and drive
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_r <= ARMDC_BOFF;
      settle_r <= 5'h00;
    end
    else
    begin
      unique case (state_r)
        ARMDC_BOFF:
        begin
          settle_r <= 5'h00;
          if (enable && inverted)
            state_r <= ARMDC_BHIZ;
          else if (enable)
            state_r <= ARMDC_BTRACK;
        end
        ARMDC_BTRACK:
        begin
          settle_r <= settle_r + 5'h01;
          if (!enable || inverted)
            state_r <= ARMDC_BOFF;
          else if (settle_r == 5'(`ARMDC_BUF_SETTLE_CYCLES - 1))
            state_r <= ARMDC_BDRIVE;
        end
        ARMDC_BDRIVE:
          if (!enable || inverted)
            state_r <= ARMDC_BOFF;
        ARMDC_BHIZ:
          if (!enable || !inverted)
            state_r <= ARMDC_BOFF;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      buf_power_r <= 1'b0;
      buf_src_dac_r <= 1'b0;
      buf_out_en_n_r <= 1'b1;
    end
    else
    begin
      buf_power_r <= (state_r == ARMDC_BTRACK) || (state_r == ARMDC_BDRIVE);
      buf_src_dac_r <= state_r == ARMDC_BDRIVE;
      buf_out_en_n_r <= !(state_r == ARMDC_BDRIVE && enable && !inverted);
    end
  end
endmodule : armdc_margin_chan

//--- armdc_limit_chk.sv
// single-threshold limit check for one readback channel
`timescale 1ns/10ps
`include "armdc_regs.svh"
module armdc_limit_chk
  import armdc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // result and threshold
  input wire logic update,
  input wire logic [11:0] result,
  input wire logic [11:0] threshold,
  input wire logic is_lower,
  input wire logic limit_en,
  // warning
  output logic warn_r
);
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      warn_r <= 1'b0;
    else if (!limit_en)
      warn_r <= 1'b0;
    else if (update)
      warn_r <= is_lower ? (result < threshold) : (result > threshold);
  end
endmodule : armdc_limit_chk

//--- armdc_ctrl.sv
// readback scan scheduler, limit warnings and six margin code channels
// Contract
// - twelve analog sources go through the converter front-end multiplexer.
// - any non-empty channel subset is converted in a fixed loop.
// - single-pass mode stops after one loop; continuous mode repeats (here only while host_start or seq_engine_scan_en stays high).
// - averaging runs the whole loop sixteen times before any result.
// - result registers update only at end of a full scan cycle.
// - each conversion gives an unsigned 12-bit code, full scale 4095.
// - each channel has one limit, upper or lower, never both.
// - crossing the limit raises a warning on status and to sequencing engine.
// - scan starts on a host write or a sequencing engine enable.
// - each channel takes about 500 us without averaging.
// - six independently controlled margin code channels.
// - 256 codes per channel, linear, 0x7f at midcode.
// - four selectable ranges per channel set the midcode voltage.
// - output equals (code-0x7f)/255 times 0.6015 V plus range offset.
// - span is 128 codes above and 127 below midcode.
// - buffer first tracks the pin, then switches to code and drives.
// - host writes a new code and the device applies it.
// - applied code is the written code clipped to lower and upper limits.
// - lower clip above upper clip holds the buffer in high impedance.
`timescale 1ns/10ps
`include "armdc_regs.svh"
module armdc_ctrl
  import armdc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // scan control
  input wire logic host_start,
  input wire logic seq_engine_scan_en,
  input wire logic continuous_mode,
  input wire logic averaging_en,
  input wire logic [11:0] channel_select,
  // converter interface
  output logic [3:0] mux_sel_r,
  output logic conv_start_r,
  input wire logic conv_done,
  input wire logic [11:0] conv_code,
  // results and limits
  output logic [12*12-1:0] result_r,
  output logic results_valid_r,
  output logic scan_busy_r,
  input wire logic [12*12-1:0] limit_threshold,
  input wire logic [11:0] limit_is_lower,
  input wire logic [11:0] limit_en,
  output logic [11:0] limit_warn_r,
  output logic seq_engine_warn_r,
  // margin code channels
  input wire logic [5:0] dac_enable,
  input wire logic [6*8-1:0] margin_code_register,
  input wire logic [6*8-1:0] margin_code_upper_clip,
  input wire logic [6*8-1:0] margin_code_lower_clip,
  input wire logic [6*2-1:0] dac_range_sel,
  output logic [6*8-1:0] dac_code_r,
  output logic [6*2-1:0] dac_range_r,
  output logic [5:0] dac_buf_power_r,
  output logic [5:0] dac_buf_src_r,
  output logic [5:0] dac_out_en_n_r
);
  localparam int CH_CYC = `ARMDC_CH_CYCLES;

  armdc_scan_t state_r;
  logic [3:0] chan_r;
  logic [3:0] pass_r;
  logic [12:0] timer_r;
  logic [11:0] sel_r;
  logic conv_pend_r;
  logic [15:0] acc_r [12];
  logic publish_r;
  logic start_req;
  logic [11:0] warn_w;
  logic [4:0] first_new;
  logic [4:0] first_cur;
  logic [4:0] step_cur;

  // next selected channel after c, no wrap; lowest selected channel when from_start
  function automatic logic [4:0] next_sel(input logic [11:0] sel, input logic [3:0] c,
                                         input logic from_start);
    logic [4:0] res;
    logic [3:0] idx;
    res = 5'h10;
    for (int k = 11; k >= 0; k--)
    begin
      idx = from_start ? 4'(k) : 4'(c + 4'(k) + 4'h1);
      if (!from_start && (32'(c) + 32'(k) + 1 > 11))
        idx = 4'h0 + 4'(32'(c) + 32'(k) + 1 - 12);
      if (sel[idx] && (from_start || (32'(c) + 32'(k) + 1 <= 11)))
        res = {1'b0, idx};
    end
    return res;
  endfunction : next_sel

  assign start_req = host_start || seq_engine_scan_en;

  // channel decodes shared by the scan states; bit 4 set means none left
  assign first_new = next_sel(channel_select, 4'h0, 1'b1);
  assign first_cur = next_sel(sel_r, 4'h0, 1'b1);
  assign step_cur = next_sel(sel_r, chan_r, 1'b0);

  // scan sequencing
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_r <= ARMDC_IDLE;
      chan_r <= 4'h0;
      pass_r <= 4'h0;
      timer_r <= 13'h0000;
      sel_r <= 12'h000;
      conv_pend_r <= 1'b0;
      publish_r <= 1'b0;
    end
    else
    begin
      publish_r <= 1'b0;
      unique case (state_r)
        ARMDC_IDLE:
          if (start_req && channel_select != 12'h000)
          begin
            sel_r <= channel_select;
            chan_r <= first_new[3:0];
            pass_r <= 4'h0;
            timer_r <= 13'h0000;
            conv_pend_r <= 1'b1;
            state_r <= ARMDC_CONV;
          end
        ARMDC_CONV:
        begin
          conv_pend_r <= 1'b0;
          timer_r <= timer_r + 13'h0001;
          if (timer_r >= 13'(CH_CYC - 1) && !conv_pend_r)
            state_r <= ARMDC_NEXT;
        end
        ARMDC_NEXT:
        begin
          timer_r <= 13'h0000;
          if (step_cur[4])
          begin
            chan_r <= first_cur[3:0];
            if (averaging_en && pass_r != 4'(`ARMDC_AVG_PASSES - 1))
            begin
              pass_r <= pass_r + 4'h1;
              conv_pend_r <= 1'b1;
              state_r <= ARMDC_CONV;
            end
            else
            begin
              publish_r <= 1'b1;
              state_r <= ARMDC_POST;
            end
          end
          else
          begin
            chan_r <= step_cur[3:0];
            conv_pend_r <= 1'b1;
            state_r <= ARMDC_CONV;
          end
        end
        ARMDC_POST:
        begin
          pass_r <= 4'h0;
          if (continuous_mode && start_req && channel_select != 12'h000)
          begin
            sel_r <= channel_select;
            chan_r <= first_new[3:0];
            conv_pend_r <= 1'b1;
            state_r <= ARMDC_CONV;
          end
          else
            state_r <= ARMDC_IDLE;
        end
      endcase
    end
  end

  // converter handshake and mux select
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      mux_sel_r <= 4'h0;
      conv_start_r <= 1'b0;
      scan_busy_r <= 1'b0;
    end
    else
    begin
      mux_sel_r <= chan_r;
      conv_start_r <= conv_pend_r;
      scan_busy_r <= state_r != ARMDC_IDLE;
    end
  end

  // accumulate conversions; publish mean at end of cycle
  generate
    for (genvar g = 0; g < `ARMDC_NUM_CH; g++)
    begin : g_ch
      always_ff @(posedge clk_sys)
      begin
        if (sys_rst)
        begin
          acc_r[g] <= 16'h0000;
          result_r[g*12 +: 12] <= 12'h000;
        end
        else
        begin
          if (publish_r)
          begin
            acc_r[g] <= 16'h0000;
            if (sel_r[g])
              result_r[g*12 +: 12] <= averaging_en ? acc_r[g][15:4] : acc_r[g][11:0];
          end
          else if (conv_done && state_r == ARMDC_CONV && chan_r == 4'(g))
            acc_r[g] <= acc_r[g] + {4'h0, conv_code};
          else if (state_r == ARMDC_IDLE)
            acc_r[g] <= 16'h0000;
        end
      end

      armdc_limit_chk u_lim (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .update(publish_r),
        .result(averaging_en ? acc_r[g][15:4] : acc_r[g][11:0]),
        .threshold(limit_threshold[g*12 +: 12]),
        .is_lower(limit_is_lower[g]),
        .limit_en(limit_en[g] & sel_r[g]),
        .warn_r(warn_w[g])
      );
    end
  endgenerate

  // warnings to status and sequencing engine
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      limit_warn_r <= 12'h000;
      seq_engine_warn_r <= 1'b0;
      results_valid_r <= 1'b0;
    end
    else
    begin
      limit_warn_r <= warn_w;
      seq_engine_warn_r <= |warn_w;
      if (publish_r)
        results_valid_r <= 1'b1;
    end
  end

  // margin code channels
  generate
    for (genvar d = 0; d < `ARMDC_NUM_DAC; d++)
    begin : g_dac
      armdc_margin_chan u_dac (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .enable(dac_enable[d]),
        .code(margin_code_register[d*8 +: 8]),
        .upper_clip(margin_code_upper_clip[d*8 +: 8]),
        .lower_clip(margin_code_lower_clip[d*8 +: 8]),
        .range_sel(dac_range_sel[d*2 +: 2]),
        .applied_code_r(dac_code_r[d*8 +: 8]),
        .range_r(dac_range_r[d*2 +: 2]),
        .buf_power_r(dac_buf_power_r[d]),
        .buf_src_dac_r(dac_buf_src_r[d]),
        .buf_out_en_n_r(dac_out_en_n_r[d])
      );
    end
  endgenerate
endmodule : armdc_ctrl

//--- armdc_ctrl_monitor.sv
// assertion checker for the scan scheduler and margin code channels
`timescale 1ns/10ps
module armdc_ctrl_monitor
  import armdc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // scan
  input wire logic [11:0] channel_select,
  input wire logic [3:0] mux_sel_r,
  input wire logic conv_start_r,
  input wire logic scan_busy_r,
  input wire logic [11:0] limit_warn_r,
  input wire logic seq_engine_warn_r,
  // margin channels
  input wire logic [47:0] margin_code_register,
  input wire logic [47:0] margin_code_upper_clip,
  input wire logic [47:0] margin_code_lower_clip,
  input wire logic [11:0] dac_range_sel,
  input wire logic [47:0] dac_code_r,
  input wire logic [11:0] dac_range_r,
  input wire logic [5:0] dac_buf_power_r,
  input wire logic [5:0] dac_buf_src_r,
  input wire logic [5:0] dac_out_en_n_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  function automatic armdc_code_t clip_code(armdc_code_t c, armdc_code_t lo, armdc_code_t hi);
    return (c < lo) ? lo : ((c > hi) ? hi : c);
  endfunction : clip_code

  conv_pulse_a: assert property (conv_start_r |=> !conv_start_r)
    else $error("conversion start longer than one cycle");
  mux_selected_a: assert property (conv_start_r |-> mux_sel_r < 4'hc && channel_select[mux_sel_r])
    else $error("conversion on an unselected channel");
  start_in_scan_a: assert property (conv_start_r |-> scan_busy_r)
    else $error("conversion outside a scan");
  warn_merge_a: assert property (seq_engine_warn_r == |limit_warn_r)
    else $error("engine warning differs from channel warnings");
  code_clip_a: assert property (
    !$past(sys_rst) && $past(margin_code_lower_clip[7:0] <= margin_code_upper_clip[7:0])
    |-> dac_code_r[7:0] == clip_code($past(margin_code_register[7:0]),
    $past(margin_code_lower_clip[7:0]), $past(margin_code_upper_clip[7:0])))
    else $error("applied code not clipped");
  range_follow_a: assert property (!$past(sys_rst) |-> dac_range_r == $past(dac_range_sel))
    else $error("range not applied");
  clip_hiz_a: assert property (
    $past(margin_code_lower_clip[47:40] > margin_code_upper_clip[47:40], 1)
    && $past(margin_code_lower_clip[47:40] > margin_code_upper_clip[47:40], 2)
    |-> dac_out_en_n_r[5] && !dac_buf_power_r[5])
    else $error("buffer not high impedance");
  track_first_a: assert property ($fell(dac_out_en_n_r[0])
    |-> dac_buf_src_r[0] && dac_buf_power_r[0] && $past(dac_buf_power_r[0], 8))
    else $error("buffer drove without tracking");
endmodule : armdc_ctrl_monitor

bind armdc_ctrl armdc_ctrl_monitor armdc_ctrl_monitor_inst (.clk_sys, .sys_rst,
  .channel_select, .mux_sel_r, .conv_start_r, .scan_busy_r, .limit_warn_r, .seq_engine_warn_r,
  .margin_code_register, .margin_code_upper_clip, .margin_code_lower_clip, .dac_range_sel,
  .dac_code_r, .dac_range_r, .dac_buf_power_r, .dac_buf_src_r, .dac_out_en_n_r);

//--- armdc_conv_model.sv
// behavioural converter answering the scan scheduler
`timescale 1ns/10ps
module armdc_conv_model (
  // clock and count clear
  input wire logic clk_sys,
  input wire logic clr,
  // converter interface
  input wire logic [3:0] mux_sel_r,
  input wire logic conv_start_r,
  output logic conv_done,
  output logic [11:0] conv_code
);
  logic [3:0] cnt [12];
  logic [3:0] ch;
  int wait_c;
  initial
  begin
    conv_done = 1'b0;
    conv_code = 12'h000;
    wait_c = 0;
  end
  // code is channel base plus the count of its conversions since clr
  always @(posedge clk_sys)
  begin
    conv_done <= 1'b0;
    if (clr)
      foreach (cnt[i]) cnt[i] <= 4'h0;
    if (conv_start_r)
    begin
      ch <= mux_sel_r;
      wait_c <= 40;
    end
    else if (wait_c == 1)
    begin
      conv_done <= 1'b1;
      conv_code <= 12'h100 + {ch, 8'h00} + {8'h00, cnt[ch]};
      cnt[ch] <= cnt[ch] + 4'h1;
      wait_c <= 0;
    end
    else
    begin
      if (wait_c > 1)
        wait_c <= wait_c - 1;
      if (conv_done)
        conv_code <= ~conv_code;
    end
  end
endmodule : armdc_conv_model

//--- tb_top.sv
// self-checking bench for the scan scheduler and margin code channels
`timescale 1ns/10ps
`include "armdc_regs.svh"
module tb_top;
  import armdc_pkg::*;
  logic clk_sys, sys_rst, host_start, seq_engine_scan_en, continuous_mode, averaging_en, clr;
  logic conv_start_r, conv_done, results_valid_r, scan_busy_r, seq_engine_warn_r;
  logic [3:0] mux_sel_r;
  logic [11:0] channel_select, conv_code, limit_is_lower, limit_en, limit_warn_r;
  logic [11:0] dac_range_sel, dac_range_r;
  logic [143:0] result_r, limit_threshold;
  logic [5:0] dac_enable, dac_buf_power_r, dac_buf_src_r, dac_out_en_n_r;
  logic [47:0] margin_code_register, margin_code_upper_clip, margin_code_lower_clip, dac_code_r;
  int miscompares = 0;
  int total_checks = 0;

  armdc_ctrl armdc_ctrl_inst (.clk_sys, .sys_rst, .host_start, .seq_engine_scan_en,
    .continuous_mode, .averaging_en, .channel_select, .mux_sel_r, .conv_start_r, .conv_done,
    .conv_code, .result_r, .results_valid_r, .scan_busy_r, .limit_threshold, .limit_is_lower,
    .limit_en, .limit_warn_r, .seq_engine_warn_r, .dac_enable, .margin_code_register,
    .margin_code_upper_clip, .margin_code_lower_clip, .dac_range_sel, .dac_code_r,
    .dac_range_r, .dac_buf_power_r, .dac_buf_src_r, .dac_out_en_n_r);
  armdc_conv_model armdc_conv_model_inst (.clk_sys, .clr, .mux_sel_r, .conv_start_r,
    .conv_done, .conv_code);

  task automatic check(input string what, input logic [143:0] exp, input logic [143:0] got);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // one scan from the chosen start source; results must still hold 2000 cycles in (40000 with averaging)
  task automatic run_scan(input logic [11:0] sel, input logic avg, input logic by_se);
    int n;
    logic [143:0] pre;
    @(posedge clk_sys);
    clr <= 1'b1;
    channel_select <= sel;
    averaging_en <= avg;
    @(posedge clk_sys);
    clr <= 1'b0;
    host_start <= !by_se;
    seq_engine_scan_en <= by_se;
    pre = result_r;
    n = 0;
    while (scan_busy_r !== 1'b1 && n < 10)
    begin
      @(posedge clk_sys);
      n++;
    end
    host_start <= 1'b0;
    seq_engine_scan_en <= 1'b0;
    repeat (avg ? 40000 : 2000) @(posedge clk_sys);
    check("results during scan", pre, result_r);
    n = 0;
    while (scan_busy_r !== 1'b0 && n < 90000)
    begin
      @(posedge clk_sys);
      n++;
    end
    check("scan ended", 1'b0, scan_busy_r);
    repeat (4) @(posedge clk_sys);
  endtask : run_scan

  // continuous scan of one channel while host_start stays high
  task automatic run_continuous;
    int n;
    int gap;
    @(posedge clk_sys);
    clr <= 1'b1;
    channel_select <= 12'h002;
    averaging_en <= 1'b0;
    continuous_mode <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    host_start <= 1'b1;
    n = 0;
    while (conv_start_r !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    gap = 1;
    while (conv_start_r !== 1'b1 && gap < 6000)
    begin
      @(posedge clk_sys);
      gap++;
    end
    check("loop restart spacing", `ARMDC_CH_CYCLES + 2, gap);
    host_start <= 1'b0;
    n = 0;
    while (scan_busy_r !== 1'b0 && n < 6000)
    begin
      @(posedge clk_sys);
      n++;
    end
    check("second loop result", 12'h201, result_r[23:12]);
    check("continuous stop", 1'b0, scan_busy_r);
    continuous_mode <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : run_continuous

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial
  begin
    #(105000 * 100);
    miscompares++;
    print_verdict();
  end

  initial
  begin
    sys_rst = 1'b1;
    {host_start, seq_engine_scan_en, continuous_mode, averaging_en, clr} = 5'h01;
    channel_select = 12'h000;
    limit_threshold = {12'hbff, 120'h0, 12'h0ff};
    limit_is_lower = 12'h800;
    limit_en = 12'h801;
    dac_enable = 6'h00;
    margin_code_register = {6{8'h7f}};
    margin_code_upper_clip = {6{8'hff}};
    margin_code_lower_clip = {6{8'h00}};
    dac_range_sel = 12'h000;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    check("reset dac code", {6{8'h7f}}, dac_code_r);
    check("reset output enable", 6'h3f, dac_out_en_n_r);
    check("reset results", 144'h0, result_r);
    $display("test reset done");
    host_start <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check("empty select busy", 1'b0, scan_busy_r);
    host_start <= 1'b0;
    $display("test empty select done");
    limit_threshold[143:132] <= 12'hbff;
    run_scan(12'h801, 1'b0, 1'b0);
    check("two channel results", {12'hc00, 120'h0, 12'h100}, result_r);
    check("limit warnings", 12'h001, limit_warn_r);
    check("engine warning", 1'b1, seq_engine_warn_r);
    check("results valid", 1'b1, results_valid_r);
    $display("test single scan done");
    run_continuous();
    $display("test continuous done");
    run_scan(12'h008, 1'b1, 1'b1);
    check("averaged result", 12'h407, result_r[47:36]);
    $display("test averaging done");
    @(posedge clk_sys);
    margin_code_register <= {8'ha1, 8'ha0, 8'h20, 8'hff, 8'h7f, 8'h10};
    margin_code_lower_clip <= {6{8'h20}};
    margin_code_upper_clip <= {6{8'ha0}};
    dac_range_sel <= 12'h4e4;
    repeat (3) @(posedge clk_sys);
    check("dac codes", {8'ha0, 8'ha0, 8'h20, 8'ha0, 8'h7f, 8'h20}, dac_code_r);
    check("dac ranges", 12'h4e4, dac_range_r);
    $display("test dac clipping done");
    margin_code_lower_clip[47:40] <= 8'hc0;
    dac_enable <= 6'h21;
    repeat (4) @(posedge clk_sys);
    check("tracking power", 1'b1, dac_buf_power_r[0]);
    check("tracking output off", 1'b1, dac_out_en_n_r[0]);
    repeat (24) @(posedge clk_sys);
    check("driving output", 2'b10, {dac_buf_src_r[0], dac_out_en_n_r[0]});
    check("crossed clips", 2'b01, {dac_buf_power_r[5], dac_out_en_n_r[5]});
    margin_code_register[7:0] <= 8'h55;
    repeat (3) @(posedge clk_sys);
    check("new code applied", 8'h55, dac_code_r[7:0]);
    $display("test dac enable done");
    print_verdict();
  end
endmodule : tb_top
